// *** verilog/otc_pkg.sv ***
package otc_pkg;

	// Widths
	localparam int CNT_W  = 16;
	localparam int TRIM_W = 9;
	localparam int TOL_W  = 10;
	localparam int DIV_W  = 5;
	localparam int SET_W  = 11;
	localparam int ADDR_W = 5;

	// Clock figures
	localparam longint CORE_HZ         = 20000000;
	localparam longint OSC_HZ          = 32000000;
	localparam longint OSC_DIV         = 32;
	localparam longint REF_HZ          = 32;
	localparam longint TGT_HZ          = OSC_HZ / OSC_DIV;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

	// Expected count, tolerance and big-step threshold
	localparam logic [CNT_W-1:0] THEORY_Z = CNT_W'(TGT_HZ / REF_HZ);
	localparam longint BIG_STEP_HUNDREDTHS = 30;
	localparam longint TOL_DIV  = 10000;
	localparam logic [CNT_W-1:0] BIG_M = CNT_W'(TGT_HZ / REF_HZ * BIG_STEP_HUNDREDTHS / TOL_DIV);
	localparam logic [TOL_W-1:0] TOL_DEFAULT = 10'h00A;

	// Trim limits and steps
	localparam logic [TRIM_W-1:0] TRIM_FLOOR   = 9'h000;
	localparam logic [TRIM_W-1:0] TRIM_CEILING = 9'h1FF;
	localparam logic [TRIM_W-1:0] TRIM_RESET   = 9'h100;
	localparam logic [TRIM_W-1:0] STEP_SMALL   = 9'h001;
	localparam logic [TRIM_W-1:0] STEP_BIG     = 9'h005;

	// Measurement progress
	localparam int SAMPLE_ACCUMULATE_COUNT = 4;
	localparam logic [2:0] MEAS_STOPPED = 3'h0;
	localparam logic [2:0] MEAS_RUNNING = 3'h1;
	localparam logic [2:0] MEAS_DONE    = 3'(SAMPLE_ACCUMULATE_COUNT + 1);

	// Calibration state codes as software sees them
	localparam logic [2:0] CODE_WAIT    = 3'h0;
	localparam logic [2:0] CODE_START   = 3'h1;
	localparam logic [2:0] CODE_ABOVE   = 3'h2;
	localparam logic [2:0] CODE_BELOW   = 3'h3;
	localparam logic [2:0] CODE_SETTLED = 3'h4;

	// Timing
	localparam longint TRIM_SETTLE_WAIT_US = 65;
	localparam int SETTLE_CYC = int'((TRIM_SETTLE_WAIT_US * CORE_HZ + 999999) / 1000000);
	localparam longint TRIGGER_RATE_HZ = 2;
	localparam int TRIGGER_CYC = int'(CORE_HZ / TRIGGER_RATE_HZ);

	// Register map and fields
	localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h00;
	localparam logic [ADDR_W-1:0] REG_TOL    = 5'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h08;
	localparam logic [ADDR_W-1:0] REG_RESULT = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_TRIM   = 5'h10;
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_KICK_BIT = 1;
	localparam int STAT_PROG_LSB = 4;
	localparam int STAT_BUSY_BIT = 8;
	localparam int RES_Z_LSB     = 16;

	typedef enum logic [4:0] {
		ST_WAIT    = 5'h01,
		ST_START   = 5'h02,
		ST_ABOVE   = 5'h04,
		ST_BELOW   = 5'h08,
		ST_SETTLED = 5'h10
	} otc_state_type;

	typedef enum logic [4:0] {
		PH_IDLE  = 5'h01,
		PH_MEAS  = 5'h02,
		PH_CLASS = 5'h04,
		PH_STEP  = 5'h08,
		PH_WAIT  = 5'h10
	} otc_phase_type;

	typedef struct packed {
		logic             done;
		logic [CNT_W-1:0] count;
	} otc_meas_type;

endpackage

// *** verilog/otc_sync.sv ***
`timescale 1ns/1ps
module otc_sync (
	input  logic clk,
	input  logic rst,
	input  logic pin,
	output logic rise
);

	logic s1;
	logic s2;
	logic s3;

	// Two-stage synchroniser, edge taken from the second stage onward
	always_ff @(posedge clk) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign rise = s2 && !s3;

endmodule

// *** verilog/otc_edge_count.sv ***
`timescale 1ns/1ps
module otc_edge_count (
	input  logic                 clk,
	input  logic                 rst,
	input  logic                 enable,
	input  logic                 ref_rise,
	input  logic                 tgt_rise,
	output otc_pkg::otc_meas_type meas
);

	logic                      armed;
	logic [otc_pkg::CNT_W-1:0] cnt;

	// Count target edges from one reference rise to the next
	always_ff @(posedge clk) begin
		if (rst || !enable) begin
			armed <= 1'b0;
			cnt   <= '0;
			meas  <= '0;
		end else begin
			meas.done <= 1'b0;
			if (ref_rise) begin
				armed <= 1'b1;
				cnt   <= '0;
				if (armed) begin
					meas.done  <= 1'b1;
					meas.count <= cnt;
				end
			end else if (armed && tgt_rise) begin
				cnt <= cnt + 1'b1;
			end
		end
	end

	a_interval_end: assert property (@(posedge clk) disable iff (rst)
		(enable && armed && ref_rise) |=> meas.done)
		else $error("reference rise did not close the interval");

endmodule

// *** verilog/otc_calibrator.sv ***
`timescale 1ns/1ps
module otc_calibrator #(
	parameter int TRIG_CYC = otc_pkg::TRIGGER_CYC
) (
	input  logic                       core_clk,
	input  logic                       rst,
	input  logic [otc_pkg::ADDR_W-1:0] avs_address,
	input  logic                       avs_read,
	input  logic                       avs_write,
	input  logic [31:0]                avs_writedata,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest,
	input  logic                       ref_clk_pin,
	input  logic                       fast_internal_oscillator,
	output logic [otc_pkg::TRIM_W-1:0] oscillator_trim_value,
	output logic                       cal_settled,
	output logic                       meas_end
);

	localparam int SET_LAST = otc_pkg::SETTLE_CYC - 1;

	logic                        ref_rise;
	logic                        osc_rise;
	logic [otc_pkg::DIV_W-1:0]   div_cnt;
	logic [31:0]                 trig_cnt;
	logic                        enable;
	logic                        kick;
	logic [otc_pkg::TOL_W-1:0]   tolerance_hundredths;
	logic [2:0]                  meas_prog;
	logic [otc_pkg::CNT_W+1:0]   sum;
	logic [otc_pkg::CNT_W-1:0]   x_hold;
	logic [otc_pkg::SET_W-1:0]   wait_cnt;
	otc_pkg::otc_state_type      state;
	otc_pkg::otc_phase_type      phase;
	otc_pkg::otc_meas_type       meas;

	// Reference and oscillator pins cross into the core clock
	otc_sync u_ref_sync (
		.clk  (core_clk),
		.rst  (rst),
		.pin  (ref_clk_pin),
		.rise (ref_rise)
	);

	otc_sync u_osc_sync (
		.clk  (core_clk),
		.rst  (rst),
		.pin  (fast_internal_oscillator),
		.rise (osc_rise)
	);

	// Divide-by-32 prescaler ahead of the edge counter
	wire tgt_rise = osc_rise && (div_cnt == otc_pkg::DIV_LAST);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_cnt <= '0;
		end else if (osc_rise) begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// Periodic trigger timer, runs only while enabled
	wire trig_hit  = (trig_cnt == 32'(TRIG_CYC - 1));
	wire idle      = (phase == otc_pkg::PH_IDLE);
	wire start_run = idle && ((enable && trig_hit) || kick);

	always_ff @(posedge core_clk) begin
		if (rst || !enable || trig_hit) begin
			trig_cnt <= '0;
		end else begin
			trig_cnt <= trig_cnt + 1'b1;
		end
	end

	// Edge counter, enabled only while measuring
	wire cnt_en = (phase == otc_pkg::PH_MEAS);

	otc_edge_count u_cnt (
		.clk      (core_clk),
		.rst      (rst),
		.enable   (cnt_en),
		.ref_rise (ref_rise),
		.tgt_rise (tgt_rise),
		.meas     (meas)
	);

	// Progress of the five-count run
	wire meas_hit  = cnt_en && meas.done;
	wire last_meas = meas_hit && (meas_prog == otc_pkg::MEAS_DONE);
	wire first_cnt = (meas_prog == otc_pkg::MEAS_RUNNING);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meas_prog <= otc_pkg::MEAS_STOPPED;
			sum       <= '0;
		end else if (start_run) begin
			meas_prog <= otc_pkg::MEAS_RUNNING;
			sum       <= '0;
		end else if (meas_hit) begin
			if (!first_cnt) begin
				sum <= sum + {2'b00, meas.count};
			end
			if (last_meas) begin
				meas_prog <= otc_pkg::MEAS_STOPPED;
			end else begin
				meas_prog <= meas_prog + 1'b1;
			end
		end
	end

	// Average of the last four counts
	wire [otc_pkg::CNT_W-1:0] avg_x = sum[otc_pkg::CNT_W+1:2];

	// Tolerance band and big-step band around the expected count
	wire [31:0] l_prod = 32'(otc_pkg::THEORY_Z) * 32'(tolerance_hundredths);
	wire [31:0] l_quot = l_prod / 32'(otc_pkg::TOL_DIV);
	wire [otc_pkg::CNT_W:0] l_val = l_quot[otc_pkg::CNT_W:0];
	wire [otc_pkg::CNT_W:0] z_val = {1'b0, otc_pkg::THEORY_Z};
	wire [otc_pkg::CNT_W:0] m_val = {1'b0, otc_pkg::BIG_M};
	wire [otc_pkg::CNT_W:0] zpl   = z_val + l_val;
	wire [otc_pkg::CNT_W:0] zml   = z_val - l_val;
	wire [otc_pkg::CNT_W:0] zpm   = z_val + m_val;
	wire [otc_pkg::CNT_W:0] zmm   = z_val - m_val;
	wire [otc_pkg::CNT_W:0] xa    = {1'b0, avg_x};
	wire [otc_pkg::CNT_W:0] xh    = {1'b0, x_hold};

	// Classification of the new average
	wire x_over  = xa > zpl;
	wire x_under = xa < zml;

	// Step selection from the held average and the current state
	wire in_above   = (state == otc_pkg::ST_ABOVE);
	wire in_below   = (state == otc_pkg::ST_BELOW);
	wire in_settled = (state == otc_pkg::ST_SETTLED);
	wire s_down_big = (in_above || in_settled) && (xh >= zpm);
	wire s_down_sml = (in_above && xh < zpm) || (in_settled && xh < zpm && xh > zpl);
	wire s_up_big   = (in_below && xh <= zmm) || (in_settled && xh < zmm);
	wire s_up_sml   = (in_below && xh > zmm) || (in_settled && xh >= zmm && xh < zml);
	wire go_down    = s_down_big || s_down_sml;
	wire go_up      = s_up_big || s_up_sml;
	wire [otc_pkg::TRIM_W-1:0] step = (s_down_big || s_up_big) ?
		otc_pkg::STEP_BIG : otc_pkg::STEP_SMALL;

	// Clamped next trim value
	wire [otc_pkg::TRIM_W-1:0] room_up = otc_pkg::TRIM_CEILING - oscillator_trim_value;
	wire [otc_pkg::TRIM_W-1:0] room_dn = oscillator_trim_value - otc_pkg::TRIM_FLOOR;
	wire [otc_pkg::TRIM_W-1:0] trim_dn = (room_dn < step) ?
		otc_pkg::TRIM_FLOOR : oscillator_trim_value - step;
	wire [otc_pkg::TRIM_W-1:0] trim_up = (room_up < step) ?
		otc_pkg::TRIM_CEILING : oscillator_trim_value + step;
	wire [otc_pkg::TRIM_W-1:0] next_trim = go_down ? trim_dn :
		(go_up ? trim_up : oscillator_trim_value);
	wire trim_moves = (next_trim != oscillator_trim_value);

	// Run sequencer: measure, classify, step, settle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			phase       <= otc_pkg::PH_IDLE;
			state       <= otc_pkg::ST_WAIT;
			x_hold      <= '0;
			cal_settled <= 1'b0;
			wait_cnt    <= '0;
		end else begin
			case (phase)
				otc_pkg::PH_IDLE: begin
					if (start_run) begin
						phase       <= otc_pkg::PH_MEAS;
						state       <= otc_pkg::ST_START;
						cal_settled <= 1'b0;
					end
				end
				otc_pkg::PH_MEAS: begin
					if (last_meas) begin
						phase <= otc_pkg::PH_CLASS;
					end
				end
				otc_pkg::PH_CLASS: begin
					x_hold <= avg_x;
					phase  <= otc_pkg::PH_STEP;
					if (x_over) begin
						state <= otc_pkg::ST_ABOVE;
					end else if (x_under) begin
						state <= otc_pkg::ST_BELOW;
					end else begin
						state       <= otc_pkg::ST_SETTLED;
						cal_settled <= 1'b1;
					end
				end
				otc_pkg::PH_STEP: begin
					wait_cnt <= '0;
					phase    <= trim_moves ? otc_pkg::PH_WAIT : otc_pkg::PH_IDLE;
				end
				otc_pkg::PH_WAIT: begin
					wait_cnt <= wait_cnt + 1'b1;
					if (wait_cnt == otc_pkg::SET_W'(SET_LAST)) begin
						phase <= otc_pkg::PH_IDLE;
					end
				end
				default: begin
					phase <= otc_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// Measurement-end event, one cycle per captured count
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meas_end <= 1'b0;
		end else begin
			meas_end <= meas_hit;
		end
	end

	// Bus access decode
	wire bus_req  = (avs_read || avs_write) && avs_waitrequest;
	wire wr_done  = avs_write && !avs_waitrequest;
	wire wr_ctrl  = wr_done && (avs_address == otc_pkg::REG_CTRL);
	wire wr_tol   = wr_done && (avs_address == otc_pkg::REG_TOL);
	wire wr_trim  = wr_done && (avs_address == otc_pkg::REG_TRIM) && idle;
	wire cal_step = (phase == otc_pkg::PH_STEP);

	// Trim register: calibration steps, software may load it while idle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			oscillator_trim_value <= otc_pkg::TRIM_RESET;
		end else if (cal_step) begin
			oscillator_trim_value <= next_trim;
		end else if (wr_trim) begin
			oscillator_trim_value <= avs_writedata[otc_pkg::TRIM_W-1:0];
		end
	end

	// Control and tolerance registers; kick is a one-shot start
	always_ff @(posedge core_clk) begin
		if (rst) begin
			enable               <= 1'b0;
			kick                 <= 1'b0;
			tolerance_hundredths <= otc_pkg::TOL_DEFAULT;
		end else begin
			kick <= wr_ctrl && avs_writedata[otc_pkg::CTRL_KICK_BIT];
			if (wr_ctrl) begin
				enable <= avs_writedata[otc_pkg::CTRL_EN_BIT];
			end
			if (wr_tol) begin
				tolerance_hundredths <= avs_writedata[otc_pkg::TOL_W-1:0];
			end
		end
	end

	// State code as software reads it
	wire [2:0] state_code =
		(state == otc_pkg::ST_START)   ? otc_pkg::CODE_START :
		(state == otc_pkg::ST_ABOVE)   ? otc_pkg::CODE_ABOVE :
		(state == otc_pkg::ST_BELOW)   ? otc_pkg::CODE_BELOW :
		(state == otc_pkg::ST_SETTLED) ? otc_pkg::CODE_SETTLED :
		otc_pkg::CODE_WAIT;

	// Read data words
	wire [31:0] rd_ctrl = 32'({enable, 1'b0}) >> 1;
	wire [31:0] rd_tol  = 32'(tolerance_hundredths);
	wire [31:0] rd_stat = 32'(state_code) | (32'(meas_prog) << otc_pkg::STAT_PROG_LSB)
		| (32'(!idle) << otc_pkg::STAT_BUSY_BIT);
	wire [31:0] rd_res  = 32'(x_hold) | (32'(otc_pkg::THEORY_Z) << otc_pkg::RES_Z_LSB);
	wire [31:0] rd_trim = 32'(oscillator_trim_value);
	wire [31:0] rd_mux  =
		(avs_address == otc_pkg::REG_CTRL)   ? rd_ctrl :
		(avs_address == otc_pkg::REG_TOL)    ? rd_tol  :
		(avs_address == otc_pkg::REG_STATUS) ? rd_stat :
		(avs_address == otc_pkg::REG_RESULT) ? rd_res  :
		(avs_address == otc_pkg::REG_TRIM)   ? rd_trim : 32'h0000_0000;

	// Avalon slave: one wait cycle, then answer for exactly one cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (bus_req) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
		end
	end

	a_run_start: assert property (@(posedge core_clk) disable iff (rst)
		start_run |=> (meas_prog == otc_pkg::MEAS_RUNNING) && cnt_en)
		else $error("run did not start measuring");

	a_first_dropped: assert property (@(posedge core_clk) disable iff (rst)
		(meas_hit && first_cnt) |=> (sum == $past(sum)))
		else $error("first count entered the sum");

	a_class_above: assert property (@(posedge core_clk) disable iff (rst)
		(phase == otc_pkg::PH_CLASS && x_over)
		|=> (state == otc_pkg::ST_ABOVE) && !cal_settled)
		else $error("average above band not classed above");

	a_above_big: assert property (@(posedge core_clk) disable iff (rst)
		(cal_step && in_above && xh >= zpm && oscillator_trim_value >= otc_pkg::STEP_BIG)
		|=> oscillator_trim_value == $past(oscillator_trim_value) - otc_pkg::STEP_BIG)
		else $error("above state did not step down by five");

	a_below_small: assert property (@(posedge core_clk) disable iff (rst)
		(cal_step && in_below && xh > zmm && room_up >= otc_pkg::STEP_SMALL)
		|=> oscillator_trim_value == $past(oscillator_trim_value) + otc_pkg::STEP_SMALL)
		else $error("below state did not step up by one");

	a_below_big: assert property (@(posedge core_clk) disable iff (rst)
		(cal_step && in_below && xh <= zmm && room_up >= otc_pkg::STEP_BIG)
		|=> oscillator_trim_value == $past(oscillator_trim_value) + otc_pkg::STEP_BIG)
		else $error("below state did not step up by five");

	a_settled_hold: assert property (@(posedge core_clk) disable iff (rst)
		(cal_step && in_settled && xh >= zml && xh <= zpl)
		|=> $stable(oscillator_trim_value) ##1 (phase == otc_pkg::PH_IDLE))
		else $error("trim moved inside tolerance band");

	a_settle_wait: assert property (@(posedge core_clk) disable iff (rst)
		(cal_step && trim_moves) |=> (phase == otc_pkg::PH_WAIT) && (wait_cnt == '0))
		else $error("no settle wait after trim change");

	a_wait_end: assert property (@(posedge core_clk) disable iff (rst)
		(phase == otc_pkg::PH_WAIT && wait_cnt == otc_pkg::SET_W'(SET_LAST))
		|=> idle && $stable(oscillator_trim_value))
		else $error("settle wait did not end on time");

	a_count_stop: assert property (@(posedge core_clk) disable iff (rst)
		!cnt_en |=> !meas.done)
		else $error("counting outside a run");

	a_meas_event: assert property (@(posedge core_clk) disable iff (rst)
		meas_hit |=> meas_end ##1 !meas_end)
		else $error("measurement-end event missing");

endmodule

// *** dv/otc_ref_source.sv ***
`timescale 1ns/1ps
// Stand-in for the external precision reference source on the reference pin
module otc_ref_source #(
	parameter int HIGH_NS  = 15865,
	parameter int LOW_NS   = 15865,
	parameter int SLOW_NS  = 30720,
	parameter int START_NS = 1000
) (
	input  wire logic slow,
	output logic      ref_clk
);

	// Free-running square wave, period shortened so that a run fits a short simulation
	initial begin
		ref_clk = 1'b0;
		#(START_NS);
		forever begin
			ref_clk = 1'b1;
			#(HIGH_NS);
			ref_clk = 1'b0;
			// Slow mode stretches only the low phase, chosen at each falling edge
			if (slow === 1'b1) #(LOW_NS + SLOW_NS);
			else #(LOW_NS);
		end
	end

endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_top;

	typedef struct packed {
		logic [4:0]  a;
		logic        w;
		logic [31:0] d;
		logic [31:0] m;
		logic [31:0] e;
	} otc_row_type;

	localparam int TRIG = 2000;
	logic        core_clk      = 1'b0;
	logic        rst           = 1'b1;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic        osc           = 1'b0;
	logic        slow          = 1'b0;
	logic [4:0]  avs_address   = 5'h00;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        ref_clk;
	logic        meas_end;
	logic        cal_settled;
	logic [8:0]  trim;
	logic [8:0]  last_trim;
	logic [31:0] rd;
	int          n_errors      = 0;
	int          checks_done   = 0;
	int          n_meas        = 0;
	int          cyc           = 0;
	int          since_chg     = 0;
	int          m0;
	int          t0;

	// Ordinary register cases: reset values, writes, unmapped place
	otc_row_type rows [11] = '{
		'{5'h04, 1'b0, 32'h0, 32'h000003FF, 32'h0000000A},
		'{5'h0C, 1'b0, 32'h0, 32'hFFFF0000, 32'h7A120000},
		'{5'h10, 1'b0, 32'h0, 32'h000001FF, 32'h00000100},
		'{5'h08, 1'b0, 32'h0, 32'h000001FF, 32'h00000000},
		'{5'h14, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h00000000},
		'{5'h14, 1'b1, 32'hFFFFFFFF, 32'h0, 32'h0},
		'{5'h14, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h00000000},
		'{5'h04, 1'b1, 32'h00000005, 32'h0, 32'h0},
		'{5'h04, 1'b0, 32'h0, 32'h000003FF, 32'h00000005},
		'{5'h10, 1'b1, 32'h000000F0, 32'h0, 32'h0},
		'{5'h10, 1'b0, 32'h0, 32'h000001FF, 32'h000000F0}
	};

	otc_calibrator #(.TRIG_CYC(TRIG)) i_otc_calibrator (
		.core_clk                 (core_clk),
		.rst                      (rst),
		.avs_address              (avs_address),
		.avs_read                 (avs_read),
		.avs_write                (avs_write),
		.avs_writedata            (avs_writedata),
		.avs_readdata             (avs_readdata),
		.avs_waitrequest          (avs_waitrequest),
		.ref_clk_pin              (ref_clk),
		.fast_internal_oscillator (osc),
		.oscillator_trim_value    (trim),
		.cal_settled              (cal_settled),
		.meas_end                 (meas_end)
	);

	otc_ref_source i_otc_ref_source (
		.slow    (slow),
		.ref_clk (ref_clk)
	);

	// System clock at 20 MHz and oscillator kept below half of it
	always #25 core_clk = ~core_clk;
	always #60 osc = ~osc;

	// Cycle count, measurement-end pulses and cycles since the last trim change
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (meas_end === 1'b1) n_meas <= n_meas + 1;
		since_chg <= (trim !== last_trim) ? 0 : since_chg + 1;
		last_trim <= trim;
	end

	// One bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		// Only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask

	// Poll status until the run is over, then check its outcome
	task automatic finish_run(input logic [8:0] texp, input logic chg);
		int   k;
		logic settle_ok;
		k = 0;
		do begin
			bus(5'h08, 1'b0, 32'h0);
			k++;
		end while (rd[8] !== 1'b0 && k < 4000);
		settle_ok = (since_chg >= otc_pkg::SETTLE_CYC - 2) &&
			(since_chg <= otc_pkg::SETTLE_CYC + 12);
		if (chg) `CHK("settle", 1'b1, settle_ok)
		`CHK("state", 3'h3, rd[2:0])
		bus(5'h0C, 1'b0, 32'h0);
		`CHK("average", 16'h0008, rd[15:0])
		`CHK("trim", texp, trim)
		`CHK("settled", 1'b0, cal_settled)
	endtask

	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		complete_run;
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		foreach (rows[i]) begin
			bus(rows[i].a, rows[i].w, rows[i].d);
			if (!rows[i].w)
				`CHK("reg_row", rows[i].e, rd & rows[i].m)
		end
		// Long first interval must be dropped; kick and trim write during the run are ignored
		slow <= 1'b1;
		m0 = n_meas;
		bus(5'h00, 1'b1, 32'h00000002);
		bus(5'h08, 1'b0, 32'h0);
		`CHK("start_code", 3'h1, rd[2:0])
		`CHK("busy", 1'b1, rd[8])
		while (n_meas - m0 < 1) @(posedge core_clk);
		slow <= 1'b0;
		bus(5'h00, 1'b1, 32'h00000002);
		bus(5'h10, 1'b1, 32'h000000AA);
		finish_run(9'h0F5, 1'b1);
		`CHK("meas_count", 5, n_meas - m0)
		// Big step near the ceiling is clamped
		bus(5'h10, 1'b1, 32'h000001FD);
		bus(5'h00, 1'b1, 32'h00000002);
		finish_run(9'h1FF, 1'b1);
		// Periodic trigger starts a run after its period
		t0 = cyc;
		bus(5'h00, 1'b1, 32'h00000001);
		while (cyc - t0 < TRIG - 100) @(posedge core_clk);
		bus(5'h08, 1'b0, 32'h0);
		`CHK("early_busy", 1'b0, rd[8])
		do bus(5'h08, 1'b0, 32'h0); while (rd[8] !== 1'b1 && cyc - t0 < TRIG + 300);
		`CHK("trig_time", 1'b1, (cyc - t0 >= TRIG && cyc - t0 <= TRIG + 16))
		bus(5'h00, 1'b1, 32'h00000000);
		finish_run(9'h1FF, 1'b0);
		// No counting while idle
		m0 = n_meas;
		repeat (3000) @(posedge core_clk);
		`CHK("idle_meas", m0, n_meas)
		// Reset in mid-run
		m0 = n_meas;
		bus(5'h00, 1'b1, 32'h00000002);
		while (n_meas - m0 < 2) @(posedge core_clk);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		`CHK("rst_trim", 9'h100, trim)
		`CHK("rst_wait", 1'b1, avs_waitrequest)
		`CHK("rst_settled", 1'b0, cal_settled)
		`CHK("rst_meas_end", 1'b0, meas_end)
		@(posedge core_clk);
		bus(5'h08, 1'b0, 32'h0);
		`CHK("rst_code", 3'h0, rd[2:0])
		complete_run;
	end

endmodule
